// ===== core/sram_port_map.svh
// offsets, fields, reset values and timing counts of the sram port
`ifndef SRAM_PORT_MAP_SVH
`define SRAM_PORT_MAP_SVH

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CAPTURE 8'h08

`define CTRL_CAPTURE_EN 0
`define CTRL_RESET 32'h0000_0000

`define STATUS_ORDER 0
`define STATUS_SLEEP 1
`define STATUS_BUSY 2
`define STATUS_READY 3
`define STATUS_LEVEL_LO 8

`define PIPE_DELAY 2
`define BURST_BITS 2
`define CAPTURE_DEPTH 8

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== core/sram_port_pkg.sv
// types shared by the sram port
package sram_port_pkg;
	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_READ = 2'b01,
		OP_WRITE = 2'b11
	} op_t;
	typedef logic [1:0] axi_resp_t;
	typedef logic [7:0] axi_addr_t;
endpackage : sram_port_pkg

// ===== core/sram_port.sv
// pipelined zero-turnaround sram port with capture fifo and axi4-lite registers
// Contract
// - all synchronous inputs registered on rising edge
// - clock gate high freezes burst, pipeline and read-drive registers, not the axi or fifo side
// - step_or_load starts read, write, deselect
// - step high increments burst counter
// - new address loads only with step low
// - two-bit burst counter drives low address
// - write starts on edge with write_n low
// - only enabled byte lanes are written
// - order strap high gives interleaved bursts
// - order strap low gives linear bursts
// - reads and writes back to back
// - one shared pin set for data
// - data and address width per variant
// - three chip selects select or deselect
// - single write_n picks read or write
// - address load presets burst counter
`timescale 1ns/10ps
`include "sram_port_map.svh"

module capture_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign level = cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
	always_ff @(posedge clk) begin
		if (push) mem_q[wr_q] <= in_data;
	end
endmodule : capture_fifo

module sram_port #(
	parameter int ADDR_W = 19,
	parameter int LANES = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic step_or_load,
	input wire logic write_n,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic chip_select_n,
	input wire logic chip_select_extra,
	input wire logic chip_select_extra_n,
	input wire logic clk_gate_n,
	input wire logic burst_order,
	input wire logic sleep_request,
	input wire logic [LANES*8-1:0] data_io_lane_in,
	output logic [LANES*8-1:0] data_io_lane_out,
	output logic data_io_lane_oe,
	input wire logic [LANES-1:0] parity_io_lane_in,
	output logic [LANES-1:0] parity_io_lane_out,
	output logic parity_io_lane_oe,
	output logic capture_ready,
	input wire logic awvalid,
	output logic awready,
	input wire sram_port_pkg::axi_addr_t awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output sram_port_pkg::axi_resp_t bresp,
	input wire logic arvalid,
	output logic arready,
	input wire sram_port_pkg::axi_addr_t araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output sram_port_pkg::axi_resp_t rresp
);
	import sram_port_pkg::*;
	localparam int WORD_W = LANES*9;
	localparam int LVL_W = $clog2(`CAPTURE_DEPTH) + 1;
	localparam logic [31:0] CTRL_RST = `CTRL_RESET;

	// memory core, lane l holds {parity, byte}
	logic [WORD_W-1:0] mem_q [2**ADDR_W];

	// strap and sleep synchronisers
	logic order_m_q, order_q, sleep_m_q, sleep_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			order_m_q <= 1'b0;
			order_q <= 1'b0;
			sleep_m_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			order_m_q <= burst_order;
			order_q <= order_m_q;
			sleep_m_q <= sleep_request;
			sleep_q <= sleep_m_q;
		end
	end

	// command decode
	wire en = !clk_gate_n;
	wire load = !step_or_load;
	wire selected = !chip_select_n && chip_select_extra && !chip_select_extra_n;
	wire op_t load_op = !selected ? OP_IDLE : (write_n ? OP_READ : OP_WRITE);

	// burst state
	logic [ADDR_W-1:0] base_q;
	logic [`BURST_BITS-1:0] start_q;
	logic [`BURST_BITS-1:0] cnt_q;
	op_t burst_op_q;
	wire [`BURST_BITS-1:0] cnt_next = cnt_q + 1'b1;
	wire [`BURST_BITS-1:0] low_ilv = start_q ^ cnt_next;
	wire [`BURST_BITS-1:0] low_lin = start_q + cnt_next;
	wire [`BURST_BITS-1:0] step_low = order_q ? low_ilv : low_lin;
	wire [ADDR_W-1:0] step_addr = {base_q[ADDR_W-1:`BURST_BITS], step_low};
	wire [ADDR_W-1:0] cmd_addr = load ? addr_in : step_addr;
	wire op_t cmd_op = load ? load_op : burst_op_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			base_q <= '0;
			start_q <= '0;
			cnt_q <= '0;
			burst_op_q <= OP_IDLE;
		end else if (en) begin
			if (load) begin
				base_q <= addr_in;
				start_q <= addr_in[`BURST_BITS-1:0];
				cnt_q <= '0;
				burst_op_q <= load_op;
			end else begin
				cnt_q <= cnt_next;
			end
		end
	end

	// two-stage command pipeline
	op_t s1_op_q, s2_op_q;
	logic [ADDR_W-1:0] s1_addr_q, s2_addr_q;
	logic [LANES-1:0] s1_be_q, s2_be_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_op_q <= OP_IDLE;
			s2_op_q <= OP_IDLE;
			s1_addr_q <= '0;
			s2_addr_q <= '0;
			s1_be_q <= '0;
			s2_be_q <= '0;
		end else if (en) begin
			s1_op_q <= cmd_op;
			s1_addr_q <= cmd_addr;
			s1_be_q <= ~byte_lane_write_n;
			s2_op_q <= s1_op_q;
			s2_addr_q <= s1_addr_q;
			s2_be_q <= s1_be_q;
		end
	end

	// execute stage: array write, read drive
	wire do_write = en && (s2_op_q == OP_WRITE);
	wire do_read = en && (s2_op_q == OP_READ);
	wire [WORD_W-1:0] rd_word = mem_q[s2_addr_q];
	logic [WORD_W-1:0] wr_word;
	always_comb begin
		wr_word = rd_word;
		for (int l = 0; l < LANES; l++) begin
			if (s2_be_q[l]) begin
				wr_word[l*9 +: 9] = {parity_io_lane_in[l], data_io_lane_in[l*8 +: 8]};
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (do_write) mem_q[s2_addr_q] <= wr_word;
	end

	logic [LANES*8-1:0] dout_q;
	logic [LANES-1:0] pout_q;
	logic oe_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_q <= '0;
			pout_q <= '0;
			oe_q <= 1'b0;
		end else if (en) begin
			oe_q <= do_read;
			if (do_read) begin
				for (int l = 0; l < LANES; l++) begin
					dout_q[l*8 +: 8] <= rd_word[l*9 +: 8];
					pout_q[l] <= rd_word[l*9+8];
				end
			end
		end
	end
	assign data_io_lane_out = dout_q;
	assign parity_io_lane_out = pout_q;
	assign data_io_lane_oe = oe_q;
	assign parity_io_lane_oe = oe_q;

	// read capture into fifo
	logic ctrl_cap_q;
	logic push_q;
	logic [WORD_W-1:0] push_data_q;
	logic fifo_in_ready, fifo_out_valid, pop;
	logic [WORD_W-1:0] fifo_out;
	logic [LVL_W-1:0] fifo_level;
	logic cap_ready_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			push_q <= 1'b0;
			push_data_q <= '0;
			cap_ready_q <= 1'b0;
		end else begin
			push_q <= do_read && ctrl_cap_q && !(push_q && !fifo_in_ready);
			if (do_read) push_data_q <= rd_word;
			cap_ready_q <= fifo_in_ready;
		end
	end
	assign capture_ready = cap_ready_q;

	capture_fifo #(.WIDTH(WORD_W), .DEPTH(`CAPTURE_DEPTH)) u_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(push_q),
		.in_ready(fifo_in_ready),
		.in_data(push_data_q),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out),
		.level(fifo_level)
	);

	// axi4-lite slave
	logic awready_q, wready_q, bvalid_q, aw_have_q, w_have_q;
	logic arready_q, rvalid_q;
	axi_addr_t aw_addr_q;
	logic [31:0] w_data_q, rdata_q;
	logic [3:0] w_strb_q;
	axi_resp_t bresp_q, rresp_q;
	wire aw_take = awvalid && awready_q;
	wire w_take = wvalid && wready_q;
	wire wr_go = aw_have_q && w_have_q && !bvalid_q;
	wire ar_take = arvalid && arready_q;
	wire hit_ctrl_w = (aw_addr_q == `REG_CTRL);
	wire hit_ctrl_r = (araddr == `REG_CTRL);
	wire hit_stat_r = (araddr == `REG_STATUS);
	wire hit_cap_r = (araddr == `REG_CAPTURE);
	wire busy = (s1_op_q != OP_IDLE) || (s2_op_q != OP_IDLE);
	assign pop = ar_take && hit_cap_r && fifo_out_valid;
	logic [31:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[`STATUS_ORDER] = order_q;
		status_word[`STATUS_SLEEP] = sleep_q;
		status_word[`STATUS_BUSY] = busy;
		status_word[`STATUS_READY] = fifo_in_ready;
		status_word[`STATUS_LEVEL_LO +: LVL_W] = fifo_level;
	end
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (hit_ctrl_r) rd_mux[`CTRL_CAPTURE_EN] = ctrl_cap_q;
		else if (hit_stat_r) rd_mux = status_word;
		else if (hit_cap_r && fifo_out_valid) rd_mux = fifo_out[31:0];
	end
	wire r_ok = hit_ctrl_r || hit_stat_r || hit_cap_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			ctrl_cap_q <= CTRL_RST[`CTRL_CAPTURE_EN];
		end else begin
			if (aw_take) begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (w_take) begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (hit_ctrl_w || aw_addr_q == `REG_STATUS
					|| aw_addr_q == `REG_CAPTURE) ? `RESP_OKAY : `RESP_SLVERR;
				if (hit_ctrl_w && w_strb_q[0]) ctrl_cap_q <= w_data_q[`CTRL_CAPTURE_EN];
			end
			if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= r_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// checks
	sequence rd_cmd;
		en && load && selected && write_n;
	endsequence
	sequence wr_cmd;
		en && load && selected && !write_n;
	endsequence
	sequence two_enabled;
		en [*2];
	endsequence

	AST_READ_LATENCY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_cmd ##1 two_enabled |=> data_io_lane_oe)
		else $error("read data not driven two enabled cycles after command");
	AST_WRITE_NO_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_cmd ##1 two_enabled |=> !data_io_lane_oe)
		else $error("pins driven during write data cycle");
	AST_SUSPEND_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_gate_n |=> $stable(cnt_q) && $stable(s2_op_q) && $stable(data_io_lane_oe))
		else $error("state moved while clock gated");
	AST_STEP_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		en && !load |=> cnt_q == $past(cnt_q) + 2'h1 && $stable(base_q))
		else $error("burst counter did not step");
	AST_LOAD_PRESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
		en && load |=> start_q == $past(addr_in[1:0]) && cnt_q == 2'h0)
		else $error("load did not preset burst start");
	AST_INTERLEAVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		en && load && order_q ##1 en && !load && order_q
		|=> s1_addr_q[1:0] == ($past(addr_in[1:0], 2) ^ 2'h1))
		else $error("interleaved step wrong");
	AST_LINEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		en && load && !order_q ##1 en && !load && !order_q ##1 en && !load && !order_q
		|=> s1_addr_q[1:0] == $past(addr_in[1:0], 3) + 2'h2)
		else $error("linear step wrong");
	AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		en && load ##1 (en && !load) [*4]
		|=> s1_addr_q[ADDR_W-1:2] == $past(addr_in[ADDR_W-1:2], 5))
		else $error("burst left its four-word block");
	AST_DESELECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		en && load && !selected |=> s1_op_q == OP_IDLE)
		else $error("deselect started an access");
	AST_WRITE_DECODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_cmd |=> s1_op_q == OP_WRITE)
		else $error("write command not decoded as write");
endmodule : sram_port

// ===== verif/mem_ctrl_model.sv
// host memory controller model driving the sram port pins
`timescale 1ns/10ps
module mem_ctrl_model #(
	parameter int ADDR_W = 8,
	parameter int LANES = 4
) (
	input wire logic clk,
	output logic [ADDR_W-1:0] addr_in,
	output logic step_or_load,
	output logic write_n,
	output logic [LANES-1:0] byte_lane_write_n,
	output logic chip_select_n,
	output logic chip_select_extra,
	output logic chip_select_extra_n,
	output logic clk_gate_n,
	output logic [LANES*8-1:0] data_io_lane_in,
	output logic [LANES-1:0] parity_io_lane_in
);
	logic wr_mode_q;
	logic wr_pipe_q;
	logic [LANES*9-1:0] word_q;
	logic [LANES*9-1:0] word_pipe_q;
	wire sel_w = !chip_select_n && chip_select_extra && !chip_select_extra_n;
	wire wr_now_w = step_or_load ? wr_mode_q : sel_w && !write_n;
	initial begin
		addr_in = '0;
		step_or_load = 1'b0;
		write_n = 1'b1;
		byte_lane_write_n = '1;
		chip_select_n = 1'b1;
		chip_select_extra = 1'b0;
		chip_select_extra_n = 1'b1;
		clk_gate_n = 1'b0;
		data_io_lane_in = '0;
		parity_io_lane_in = '0;
		wr_mode_q = 1'b0;
		wr_pipe_q = 1'b0;
	end
	// write data on pins two enabled edges on, a toggling pattern otherwise
	always @(posedge clk) begin
		if (!clk_gate_n) begin
			if (!step_or_load) wr_mode_q <= sel_w && !write_n;
			wr_pipe_q <= wr_now_w;
			word_pipe_q <= word_q;
			for (int l = 0; l < LANES; l++) begin
				data_io_lane_in[8*l+:8] <= wr_pipe_q ? word_pipe_q[9*l+:8] : ~data_io_lane_in[8*l+:8];
				parity_io_lane_in[l] <= wr_pipe_q ? word_pipe_q[9*l+8] : ~parity_io_lane_in[l];
			end
		end
	end
	task automatic issue(input logic [2:0] cs, input logic ld, input logic wr,
		input logic [ADDR_W-1:0] a, input logic [LANES-1:0] be_n, input logic [LANES*9-1:0] w);
		chip_select_n <= !cs[0];
		chip_select_extra <= cs[1];
		chip_select_extra_n <= !cs[2];
		step_or_load <= !ld;
		addr_in <= a;
		write_n <= !wr;
		byte_lane_write_n <= be_n;
		word_q <= w;
		@(posedge clk);
	endtask : issue
	// gated cycles carrying a bogus write load
	task automatic hold_clock(input int n, input logic [ADDR_W-1:0] a);
		clk_gate_n <= 1'b1;
		step_or_load <= 1'b0;
		write_n <= 1'b0;
		byte_lane_write_n <= '0;
		addr_in <= a;
		repeat (n) @(posedge clk);
		clk_gate_n <= 1'b0;
	endtask : hold_clock
endmodule : mem_ctrl_model

// ===== verif/sram_port_tb.sv
// self-checking bench of the sram port: bursts, gating, lanes, capture fifo, registers
`timescale 1ns/10ps
`include "sram_port_map.svh"
`define CHK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		error_cnt++; \
		$display("mismatch at %0t got %h exp %h", $time, got, exp); \
	end \
end
module sram_port_tb;
	import sram_port_pkg::*;
	typedef struct {int cyc; logic [35:0] val;} exp_t;
	logic ref_clk, rst_n, burst_order, sleep_request, awvalid, wvalid, bready, arvalid, rready;
	axi_addr_t awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic [3:0] wstrb;
	logic [7:0] addr_in, base, rb;
	logic step_or_load, write_n, chip_select_n, chip_select_extra, chip_select_extra_n, clk_gate_n;
	logic [3:0] byte_lane_write_n, parity_io_lane_in, parity_io_lane_out;
	logic [31:0] data_io_lane_in, data_io_lane_out, rdata, wdata;
	logic data_io_lane_oe, parity_io_lane_oe, capture_ready, awready, wready, bvalid, arready, rvalid;
	axi_resp_t bresp, rresp;
	int error_cnt, checks_done, en_cnt_q;
	logic en_edge_q, cap_on;
	logic [15:0] lfsr_q = 16'h6bc0;
	logic [35:0] mem_ref [256];
	logic [35:0] rd_word, t36;
	logic [33:0] ax;
	exp_t e;
	exp_t pq[$];
	logic [33:0] aq[$];
	logic [31:0] cq[$];
	mem_ctrl_model #(.ADDR_W(8), .LANES(4)) mem_ctrl_model_inst (.clk(ref_clk), .addr_in,
		.step_or_load, .write_n, .byte_lane_write_n, .chip_select_n, .chip_select_extra,
		.chip_select_extra_n, .clk_gate_n, .data_io_lane_in, .parity_io_lane_in);
	sram_port #(.ADDR_W(8), .LANES(4)) sram_port_inst (.ref_clk, .rst_n, .addr_in,
		.step_or_load, .write_n, .byte_lane_write_n, .chip_select_n, .chip_select_extra,
		.chip_select_extra_n, .clk_gate_n, .burst_order, .sleep_request, .data_io_lane_in,
		.data_io_lane_out, .data_io_lane_oe, .parity_io_lane_in, .parity_io_lane_out,
		.parity_io_lane_oe, .capture_ready, .awvalid, .awready, .awaddr, .awprot,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .arprot, .rvalid, .rready, .rdata, .rresp);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		en_edge_q <= !clk_gate_n;
		if (!clk_gate_n) en_cnt_q <= en_cnt_q + 1;
		if ((rvalid && rready) || (bvalid && bready)) begin
			ax = aq.pop_front();
			`CHK(rvalid ? {rresp, rdata} : {bresp, 32'h0}, ax)
		end
	end
	always @(negedge ref_clk) begin
		if (en_edge_q && data_io_lane_oe === 1'b1) begin
			e = '{-1, 36'h0};
			if (pq.size() > 0) e = pq.pop_front();
			for (int l = 0; l < 4; l++) begin
				rd_word[9*l+:9] = {parity_io_lane_out[l], data_io_lane_out[8*l+:8]};
			end
			`CHK(en_cnt_q, e.cyc)
			`CHK(rd_word, e.val)
			`CHK(parity_io_lane_oe, 1'b1)
		end
	end
	task automatic give_verdict();
		if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	function automatic logic [35:0] rw();
		logic [47:0] t;
		for (int i = 0; i < 3; i++) begin
			lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			t = {t[31:0], lfsr_q};
		end
		return t[35:0];
	endfunction : rw
	function automatic logic [7:0] baddr(input logic [7:0] a, input logic [1:0] n);
		return {a[7:2], burst_order ? a[1:0] ^ n : a[1:0] + n};
	endfunction : baddr
	task automatic pin(input logic [2:0] cs, input logic ld, input logic wr, input logic [7:0] pa,
		input logic [7:0] ra, input logic [3:0] be_n, input logic [35:0] w);
		if (cs == 3'b111 && !wr) pq.push_back('{en_cnt_q + 4, mem_ref[ra]});
		if (cs == 3'b111 && !wr && cap_on && cq.size() < 8) cq.push_back(mem_ref[ra][31:0]);
		for (int l = 0; l < 4; l++) begin
			if (cs == 3'b111 && wr && !be_n[l]) mem_ref[ra][9*l+:9] = w[9*l+:9];
		end
		mem_ctrl_model_inst.issue(cs, ld, wr, pa, be_n, w);
	endtask : pin
	task automatic idle(input int n);
		repeat (n) pin(3'b000, 1'b1, 1'b0, 8'h0, 8'h0, 4'hf, 36'h0);
	endtask : idle
	task automatic axw(input axi_addr_t a, input logic [31:0] d, input axi_resp_t r);
		int n;
		aq.push_back({r, 32'h0});
		awaddr <= a;
		awprot <= d[2:0];
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) error_cnt++;
		if (n == 50) give_verdict();
	endtask : axw
	task automatic axr(input axi_addr_t a, input logic [33:0] x);
		int n;
		aq.push_back(x);
		araddr <= a;
		arprot <= a[2:0];
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) error_cnt++;
		if (n == 50) give_verdict();
	endtask : axr
	initial begin
		{rst_n, burst_order, awvalid, wvalid, bready, arvalid, rready, cap_on} = '0;
		sleep_request = 1'b1;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		{awprot, arprot} = '0;
		wstrb = 4'hf;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int o = 0; o < 2; o++) begin
			burst_order <= o[0];
			idle(3);
			t36 = rw();
			base = t36[7:0];
			rb = base ^ 8'h1;
			for (int n = 0; n < 4; n++) begin
				pin(3'b111, n == 0, 1'b1, n == 0 ? base : ~base, baddr(base, n[1:0]), 4'h0, rw());
			end
			for (int n = 0; n < 5; n++) begin
				pin(3'b111, n == 0, 1'b0, n == 0 ? rb : ~rb, baddr(rb, n[1:0]), 4'hf, 36'h0);
			end
			pin(3'b111, 1'b1, 1'b1, rb, rb, 4'h0, rw());
			pin(3'b111, 1'b1, 1'b0, rb, rb, 4'hf, 36'h0);
			for (int l = 0; l < 5; l++) begin
				pin(3'b111, 1'b1, 1'b1, base, base, ~(4'h1 << l), rw());
				pin(3'b111, 1'b1, 1'b0, base, base, 4'hf, 36'h0);
			end
			for (int c = 0; c < 3; c++) begin
				pin(3'b111 ^ (3'b001 << c), 1'b1, 1'b1, base, base, 4'h0, rw());
				pin(3'b111 ^ (3'b001 << c), 1'b0, 1'b1, ~base, base, 4'h0, rw());
			end
			pin(3'b111, 1'b1, 1'b0, base, base, 4'hf, 36'h0);
			pin(3'b111, 1'b0, 1'b0, ~base, baddr(base, 2'd1), 4'hf, 36'h0);
			mem_ctrl_model_inst.hold_clock(3, base);
			idle(1);
			pin(3'b111, 1'b1, 1'b0, base, base, 4'hf, 36'h0);
		end
		idle(1);
		axr(`REG_CTRL, {`RESP_OKAY, `CTRL_RESET});
		axw(`REG_CTRL, 32'h1, `RESP_OKAY);
		cap_on = 1'b1;
		for (int i = 0; i < 10; i++) begin
			pin(3'b111, 1'b1, 1'b0, {base[7:2], i[1:0]}, {base[7:2], i[1:0]}, 4'hf, 36'h0);
		end
		idle(3);
		axr(`REG_STATUS, {`RESP_OKAY, 20'h0, 4'h8, 4'h0, 2'b00, 1'b1, burst_order});
		`CHK(capture_ready, 1'b0)
		sleep_request <= 1'b0;
		for (int i = 0; i < 8; i++) axr(`REG_CAPTURE, {`RESP_OKAY, cq.pop_front()});
		axr(`REG_STATUS, {`RESP_OKAY, 20'h0, 4'h0, 4'h0, 2'b10, 1'b0, burst_order});
		`CHK(capture_ready, 1'b1)
		axw(8'h10, 32'h5, `RESP_SLVERR);
		axr(8'h10, {`RESP_SLVERR, 32'h0});
		axw(`REG_STATUS, 32'hf, `RESP_OKAY);
		wstrb <= 4'he;
		axw(`REG_CTRL, 32'h0, `RESP_OKAY);
		axr(`REG_CTRL, {`RESP_OKAY, 32'h1});
		idle(4);
		`CHK(pq.size(), 0)
		give_verdict();
	end
endmodule : sram_port_tb
